// *** rssd_pkg.sv ***
package rssd_pkg;

	// Datapath geometry.
	localparam int BYTE_W = 8;
	localparam int NIBBLE_W = 4;
	localparam int MSB_IDX = 7;
	localparam int LSB_IDX = 0;
	localparam int BIT_SEL_W = 3;

	// Constant operands and reset values.
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
	localparam logic [7:0] WREG_RST = 8'h00;
	localparam logic FLAG_RST = 1'b0;

	// Operations accepted from the instruction decoder.
	typedef enum logic [4:0] {
		OP_IDLE,
		OP_ROTL_THRU_CARRY_TO_WREG,
		OP_ROTATE_RIGHT_INPLACE,
		OP_ROTATE_RIGHT_TO_WREG,
		OP_ROTR_THRU_CARRY_INPLACE,
		OP_ROTR_THRU_CARRY_TO_WREG,
		OP_MINUS_WITH_BORROW,
		OP_MINUS_WITH_BORROW_TO_MEM,
		OP_MINUS_WITH_BORROW_IMM,
		OP_MINUS_PLAIN,
		OP_MINUS_PLAIN_TO_MEM,
		OP_MINUS_PLAIN_IMM,
		OP_DECREMENT_SKIP_NULL,
		OP_DECREMENT_SKIP_NULL_WREG,
		OP_INCREMENT_SKIP_NULL,
		OP_INCREMENT_SKIP_NULL_WREG,
		OP_SET_BYTE,
		OP_SET_BIT,
		OP_SKIP_BIT_NONNULL,
		OP_SKIP_IF_NONNULL,
		OP_NIBBLE_EXCHANGE_INPLACE,
		OP_NIBBLE_EXCHANGE_TO_WREG
	} rssd_op_t;

	// Sequencer states.
	typedef enum logic {
		ST_READY,
		ST_DUMMY
	} rssd_state_t;

endpackage : rssd_pkg

// *** rssd_sub_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

// Eight-bit subtractor with borrow-in, producing no-borrow, half no-borrow
// and signed overflow indications.
module rssd_sub_unit
	import rssd_pkg::*;
#(
	parameter int WIDTH = BYTE_W
) (
	// Operands.
	input wire logic [WIDTH-1:0] minuend,
	input wire logic [WIDTH-1:0] subtrahend,
	input wire logic borrowIn,
	// Results.
	output logic [WIDTH-1:0] difference,
	output logic noBorrow,
	output logic halfNoBorrow,
	output logic signedOverflow
);

	if (WIDTH != BYTE_W) begin : g_width_check
		$error("rssd_sub_unit supports only an eight-bit width");
	end

	logic [WIDTH:0] fullDiff;
	logic [NIBBLE_W:0] lowDiff;

	assign fullDiff = {1'b0, minuend} - {1'b0, subtrahend} - {{WIDTH{1'b0}}, borrowIn};
	assign lowDiff = {1'b0, minuend[NIBBLE_W-1:0]} - {1'b0, subtrahend[NIBBLE_W-1:0]}
		- {{NIBBLE_W{1'b0}}, borrowIn};
	assign difference = fullDiff[WIDTH-1:0];
	assign noBorrow = ~fullDiff[WIDTH];
	assign halfNoBorrow = ~lowDiff[NIBBLE_W];
	assign signedOverflow = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1])
		& (minuend[WIDTH-1] ^ fullDiff[WIDTH-1]);

endmodule : rssd_sub_unit

`default_nettype wire

// *** rssd_datapath.sv ***
// How it works
// [RULE1] Left rotate through carry to working reg; old carry to bit 0, bit 7 to carry.
// [RULE2] Right rotate in place, bit 0 wraps to bit 7, flags untouched.
// [RULE3] Right rotate into working reg, memory untouched, flags untouched.
// [RULE4] Right rotate through carry; old carry to bit 7, bit 0 to carry.
// [RULE5] Working reg minus memory minus inverted carry, to wreg or memory; carry = no borrow.
// [RULE6] Working reg minus immediate minus inverted carry into wreg; carry = no borrow.
// [RULE7] Every subtract updates overflow, zero, half carry, carry, sign compare, chained null.
// [RULE8] Working reg minus memory, to memory or wreg; carry cleared on negative.
// [RULE9] Working reg minus immediate into wreg; carry cleared on negative.
// [RULE10] Decrement memory byte, skip next on zero; memory or wreg only; no flags.
// [RULE11] Increment memory byte, skip next on zero; memory or wreg only; no flags.
// [RULE12] Wreg variants skip on the wreg value and leave memory unchanged.
// [RULE13] Every skip-type operation takes two cycles through an inserted dummy cycle.
// [RULE14] Set byte writes all ones to memory, no flags.
// [RULE15] Set bit forces only the selected bit to one, no flags.
// [RULE16] Bit nonzero test skips next when selected bit is one, no flags.
// [RULE17] Byte nonzero test writes value back, skips when nonzero, no flags.
// [RULE18] Nibble exchange in place, or into wreg with memory unchanged, no flags.
// [RULE19] All operands and results are eight bits, results truncated.
`timescale 1ns/1ps
`default_nettype none

module rssd_datapath
	import rssd_pkg::*;
#(
	parameter int WIDTH = BYTE_W
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_b,
	// Operation request from the decoder.
	input wire logic opValid,
	input wire rssd_op_t opCode,
	input wire logic [WIDTH-1:0] memData,
	input wire logic [WIDTH-1:0] immData,
	input wire logic [BIT_SEL_W-1:0] bitSel,
	output logic opReady,
	// Data memory write-back.
	output logic memWrEn,
	output logic [WIDTH-1:0] memWrData,
	// Program flow.
	output logic skipNext,
	// Working register and status flags.
	output logic [WIDTH-1:0] workingReg,
	output logic carryFlag,
	output logic zeroFlag,
	output logic signedOverflowFlag,
	output logic halfCarryFlag,
	output logic signCompareFlag,
	output logic chainedNullFlag
);

	// Elaboration stops on a width that the fixed eight-bit logic cannot serve.
	if (WIDTH != BYTE_W) begin : g_width_check
		$error("rssd_datapath supports only an eight-bit width");
	end
	if ((2 ** BIT_SEL_W) != WIDTH) begin : g_bitsel_check
		$error("rssd_datapath needs a bit selector that spans the whole byte");
	end

	// Right rotate with a chosen bit entering at the top.
	function automatic logic [WIDTH-1:0] rotRight(input logic [WIDTH-1:0] v, input logic inBit);
		rotRight = {inBit, v[MSB_IDX:LSB_IDX+1]};
	endfunction : rotRight

	function automatic logic isNull(input logic [WIDTH-1:0] v);
		isNull = (v == BYTE_ZERO);
	endfunction : isNull

	// Sequencer state.
	rssd_state_t state_reg;
	rssd_state_t state_next;

	// Working register and flags.
	logic [WIDTH-1:0] wreg_reg;
	logic [WIDTH-1:0] wreg_next;
	logic carry_reg;
	logic carry_next;
	logic zero_reg;
	logic zero_next;
	logic ovf_reg;
	logic ovf_next;
	logic half_reg;
	logic half_next;
	logic scmp_reg;
	logic scmp_next;
	logic cnull_reg;
	logic cnull_next;

	// Write-back, skip and ready pulses.
	logic memWrEn_reg;
	logic memWrEn_next;
	logic [WIDTH-1:0] memWrData_reg;
	logic [WIDTH-1:0] memWrData_next;
	logic skip_reg;
	logic skip_next;
	logic ready_reg;
	logic ready_next;

	// Operation acceptance and classification.
	wire take = opValid & ready_reg & (state_reg == ST_READY);

	wire opWithBorrow = (opCode == OP_MINUS_WITH_BORROW)
		| (opCode == OP_MINUS_WITH_BORROW_TO_MEM)
		| (opCode == OP_MINUS_WITH_BORROW_IMM);
	wire opPlainSub = (opCode == OP_MINUS_PLAIN)
		| (opCode == OP_MINUS_PLAIN_TO_MEM)
		| (opCode == OP_MINUS_PLAIN_IMM);
	wire opSub = opWithBorrow | opPlainSub;
	wire opImm = (opCode == OP_MINUS_WITH_BORROW_IMM) | (opCode == OP_MINUS_PLAIN_IMM);
	// Every skip-type operation costs a dummy cycle, whether it skips or not.
	wire opSkipType = (opCode == OP_DECREMENT_SKIP_NULL)
		| (opCode == OP_DECREMENT_SKIP_NULL_WREG)
		| (opCode == OP_INCREMENT_SKIP_NULL)
		| (opCode == OP_INCREMENT_SKIP_NULL_WREG)
		| (opCode == OP_SKIP_BIT_NONNULL)
		| (opCode == OP_SKIP_IF_NONNULL);

	// Shared arithmetic and bit manipulation.
	// The carry-through rotates use the carry as it stood before this operation.
	wire [WIDTH-1:0] rotlCarry = {memData[MSB_IDX-1:LSB_IDX], carry_reg}; // RULE1
	wire [WIDTH-1:0] rotrWrap = rotRight(memData, memData[LSB_IDX]); // RULE2
	wire [WIDTH-1:0] rotrCarry = rotRight(memData, carry_reg); // RULE4
	wire [WIDTH-1:0] decValue = memData - BYTE_ONE; // RULE19
	wire [WIDTH-1:0] incValue = memData + BYTE_ONE; // RULE19
	wire [WIDTH-1:0] bitMask = BYTE_ONE << bitSel;
	wire [WIDTH-1:0] swapped = {memData[NIBBLE_W-1:0], memData[MSB_IDX:NIBBLE_W]}; // RULE18
	wire [WIDTH-1:0] setBitValue = memData | bitMask; // RULE15
	wire selBitSet = memData[bitSel];

	// Skip decisions, taken on the value that each operation produces.
	wire decSkip = isNull(decValue);
	wire incSkip = isNull(incValue);
	wire byteNonNull = ~isNull(memData);

	// Subtract operands: borrow-in is the inverted carry only for the borrow forms.
	wire [WIDTH-1:0] subOperand = opImm ? immData : memData;
	wire borrowIn = opWithBorrow & ~carry_reg; // RULE5 RULE6
	wire [WIDTH-1:0] subDiff;
	wire subNoBorrow;
	wire subHalfNoBorrow;
	wire subOverflow;

	// One subtractor serves all six subtract forms; only the operand and the
	// borrow-in differ between them.
	rssd_sub_unit #(
		.WIDTH(WIDTH)
	) i_rssd_sub_unit (
		.minuend(wreg_reg),
		.subtrahend(subOperand),
		.borrowIn(borrowIn),
		.difference(subDiff),
		.noBorrow(subNoBorrow),
		.halfNoBorrow(subHalfNoBorrow),
		.signedOverflow(subOverflow)
	);

	wire subZero = isNull(subDiff);
	// Sign compare tells signed less-than: overflow xor result sign.
	wire subSignCmp = subOverflow ^ subDiff[MSB_IDX];
	// The borrow forms chain the null flag across bytes of a multi-byte subtract.
	wire subChained = opWithBorrow ? (subZero & cnull_reg) : subZero;

	// Per-operation result selection.
	// memWrData keeps its last value between pulses, so the write-back bus only
	// moves when a write is made.
	always_comb begin
		wreg_next = wreg_reg;
		carry_next = carry_reg;
		memWrEn_next = 1'b0;
		memWrData_next = memWrData_reg;
		skip_next = 1'b0;
		// Unknown or refused operations leave every register as it stands, except the write and skip pulses, which drop to zero.
		if (take) begin
			unique case (opCode)
				OP_ROTL_THRU_CARRY_TO_WREG: begin
					wreg_next = rotlCarry; // RULE1
					carry_next = memData[MSB_IDX]; // RULE1
				end
				OP_ROTATE_RIGHT_INPLACE: begin
					memWrEn_next = 1'b1; // RULE2
					memWrData_next = rotrWrap; // RULE2
				end
				OP_ROTATE_RIGHT_TO_WREG: begin
					wreg_next = rotrWrap; // RULE3
				end
				OP_ROTR_THRU_CARRY_INPLACE: begin
					memWrEn_next = 1'b1; // RULE4
					memWrData_next = rotrCarry; // RULE4
					carry_next = memData[LSB_IDX]; // RULE4
				end
				OP_ROTR_THRU_CARRY_TO_WREG: begin
					wreg_next = rotrCarry; // RULE4
					carry_next = memData[LSB_IDX]; // RULE4
				end
				OP_MINUS_WITH_BORROW, OP_MINUS_WITH_BORROW_IMM: begin
					wreg_next = subDiff; // RULE5 RULE6
					carry_next = subNoBorrow; // RULE5 RULE6
				end
				OP_MINUS_PLAIN, OP_MINUS_PLAIN_IMM: begin
					wreg_next = subDiff; // RULE8 RULE9
					carry_next = subNoBorrow; // RULE8 RULE9
				end
				OP_MINUS_WITH_BORROW_TO_MEM, OP_MINUS_PLAIN_TO_MEM: begin
					memWrEn_next = 1'b1; // RULE5 RULE8
					memWrData_next = subDiff; // RULE5 RULE8
					carry_next = subNoBorrow; // RULE5 RULE8
				end
				OP_DECREMENT_SKIP_NULL: begin
					memWrEn_next = 1'b1; // RULE10
					memWrData_next = decValue; // RULE10
					skip_next = decSkip; // RULE10
				end
				// The working-register forms skip on the new value and never write memory.
				OP_DECREMENT_SKIP_NULL_WREG: begin
					wreg_next = decValue; // RULE10 RULE12
					skip_next = decSkip; // RULE12
				end
				OP_INCREMENT_SKIP_NULL: begin
					memWrEn_next = 1'b1; // RULE11
					memWrData_next = incValue; // RULE11
					skip_next = incSkip; // RULE11
				end
				OP_INCREMENT_SKIP_NULL_WREG: begin
					wreg_next = incValue; // RULE11 RULE12
					skip_next = incSkip; // RULE12
				end
				OP_SET_BYTE: begin
					memWrEn_next = 1'b1; // RULE14
					memWrData_next = BYTE_ALL_ONES; // RULE14
				end
				OP_SET_BIT: begin
					memWrEn_next = 1'b1; // RULE15
					memWrData_next = setBitValue; // RULE15
				end
				OP_SKIP_BIT_NONNULL: begin
					skip_next = selBitSet; // RULE16
				end
				OP_SKIP_IF_NONNULL: begin
					memWrEn_next = 1'b1; // RULE17
					memWrData_next = memData; // RULE17
					skip_next = byteNonNull; // RULE17
				end
				OP_NIBBLE_EXCHANGE_INPLACE: begin
					memWrEn_next = 1'b1; // RULE18
					memWrData_next = swapped; // RULE18
				end
				OP_NIBBLE_EXCHANGE_TO_WREG: begin
					wreg_next = swapped; // RULE18
				end
				OP_IDLE: begin
				end
				default: begin
				end
			endcase
		end
	end

	// Arithmetic flags move only on subtract operations.
	// Carry is set in the result selection, since the rotates move it too.
	wire subTaken = take & opSub; // RULE7
	assign zero_next = subTaken ? subZero : zero_reg; // RULE7
	assign ovf_next = subTaken ? subOverflow : ovf_reg; // RULE7
	assign half_next = subTaken ? subHalfNoBorrow : half_reg; // RULE7
	assign scmp_next = subTaken ? subSignCmp : scmp_reg; // RULE7
	assign cnull_next = subTaken ? subChained : cnull_reg; // RULE7

	// Skip-type operations hold off the decoder for one dummy cycle.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_READY: begin
				if (take & opSkipType) begin
					state_next = ST_DUMMY; // RULE13
				end
			end
			ST_DUMMY: begin
				state_next = ST_READY; // RULE13
			end
		endcase
	end
	assign ready_next = (state_next == ST_READY); // RULE13

	// The ready flop mirrors the state, so opReady comes straight from a flip-flop.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_READY;
			ready_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			ready_reg <= ready_next;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wreg_reg <= WREG_RST;
			carry_reg <= FLAG_RST;
			zero_reg <= FLAG_RST;
			ovf_reg <= FLAG_RST;
			half_reg <= FLAG_RST;
			scmp_reg <= FLAG_RST;
			cnull_reg <= FLAG_RST;
		end else begin
			wreg_reg <= wreg_next;
			carry_reg <= carry_next;
			zero_reg <= zero_next;
			ovf_reg <= ovf_next;
			half_reg <= half_next;
			scmp_reg <= scmp_next;
			cnull_reg <= cnull_next;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			memWrEn_reg <= 1'b0;
			memWrData_reg <= BYTE_ZERO;
			skip_reg <= 1'b0;
		end else begin
			memWrEn_reg <= memWrEn_next;
			memWrData_reg <= memWrData_next;
			skip_reg <= skip_next;
		end
	end

	// Every output is the plain output of its flip-flop.
	assign opReady = ready_reg;
	assign memWrEn = memWrEn_reg;
	assign memWrData = memWrData_reg;
	assign skipNext = skip_reg;
	assign workingReg = wreg_reg;
	assign carryFlag = carry_reg;
	assign zeroFlag = zero_reg;
	assign signedOverflowFlag = ovf_reg;
	assign halfCarryFlag = half_reg;
	assign signCompareFlag = scmp_reg;
	assign chainedNullFlag = cnull_reg;

endmodule : rssd_datapath

`default_nettype wire

// *** rssd_datapath_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module rssd_datapath_assertions
	import rssd_pkg::*;
#(
	parameter int WIDTH = BYTE_W
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_b,
	// Request.
	input wire logic opValid,
	input wire rssd_op_t opCode,
	input wire logic [WIDTH-1:0] memData,
	input wire logic [WIDTH-1:0] immData,
	input wire logic opReady,
	// Results.
	input wire logic memWrEn,
	input wire logic [WIDTH-1:0] memWrData,
	input wire logic skipNext,
	input wire logic [WIDTH-1:0] workingReg,
	input wire logic carryFlag
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	logic tk;
	logic sk;
	assign tk = opValid && opReady;
	assign sk = opCode inside {OP_DECREMENT_SKIP_NULL, OP_DECREMENT_SKIP_NULL_WREG,
		OP_INCREMENT_SKIP_NULL, OP_INCREMENT_SKIP_NULL_WREG, OP_SKIP_BIT_NONNULL,
		OP_SKIP_IF_NONNULL};
	dummy_slot_a: assert property (tk && sk |=> !opReady ##1 opReady)
		else $error("skip op dummy slot wrong");
	rotl_carry_a: assert property (tk && opCode == OP_ROTL_THRU_CARRY_TO_WREG |=>
		{carryFlag, workingReg} == {$past(memData), $past(carryFlag)} && !memWrEn)
		else $error("left rotate through carry wrong");
	rotr_carry_a: assert property (tk && opCode == OP_ROTR_THRU_CARRY_TO_WREG |=>
		{workingReg, carryFlag} == {$past(carryFlag), $past(memData)} && !memWrEn)
		else $error("right rotate through carry wrong");
	rotr_mem_a: assert property (tk && opCode == OP_ROTATE_RIGHT_INPLACE |=>
		memWrEn && {memWrData[6:0], memWrData[7]} == $past(memData))
		else $error("right rotate in place wrong");
	swap_wreg_a: assert property (tk && opCode == OP_NIBBLE_EXCHANGE_TO_WREG |=>
		{workingReg[3:0], workingReg[7:4]} == $past(memData) && !memWrEn)
		else $error("nibble exchange wrong");
	dec_skip_a: assert property (tk && opCode == OP_DECREMENT_SKIP_NULL |=>
		memWrEn && memWrData + BYTE_ONE == $past(memData) && skipNext == (memWrData == BYTE_ZERO))
		else $error("decrement skip wrong");
	inc_wreg_a: assert property (tk && opCode == OP_INCREMENT_SKIP_NULL_WREG |=>
		!memWrEn && workingReg == $past(memData) + BYTE_ONE
		&& skipNext == (workingReg == BYTE_ZERO))
		else $error("increment skip to wreg wrong");
	set_byte_a: assert property (tk && opCode == OP_SET_BYTE |=>
		memWrEn && memWrData == BYTE_ALL_ONES)
		else $error("set byte wrong");
	sub_imm_a: assert property (tk && opCode == OP_MINUS_PLAIN_IMM |=>
		workingReg == $past(workingReg) - $past(immData)
		&& carryFlag == ($past(workingReg) >= $past(immData)))
		else $error("immediate subtract wrong");
	cover property (tk && sk ##1 skipNext);
	cover property (tk && opCode == OP_MINUS_WITH_BORROW_TO_MEM);
	cover property (memWrEn && memWrData == BYTE_ZERO);
endmodule : rssd_datapath_assertions

bind rssd_datapath rssd_datapath_assertions #(.WIDTH(WIDTH)) i_rssd_datapath_assertions (
	.sys_clk, .rst_b, .opValid, .opCode, .memData, .immData, .opReady,
	.memWrEn, .memWrData, .skipNext, .workingReg, .carryFlag
);

`default_nettype wire

// *** rssd_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// One data memory byte at the address the decoder holds; the bench preloads it.
module rssd_mem_model (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_b,
	// Preload.
	input wire logic ld,
	input wire logic [7:0] ldVal,
	// Datapath side.
	input wire logic memWrEn,
	input wire logic [7:0] memWrData,
	output logic [7:0] memData
);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			memData <= 8'h00;
		else if (ld)
			memData <= ldVal;
		else if (memWrEn)
			memData <= memWrData;
	end
endmodule : rssd_mem_model

`default_nettype wire

// *** tb_rssd_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_rssd_datapath
	import rssd_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic opValid = 1'b0;
	rssd_op_t opCode = OP_IDLE;
	logic [7:0] immData = 8'h00;
	logic [2:0] bitSel = 3'h0;
	logic ld = 1'b0;
	logic [7:0] ldVal = 8'h00;
	logic opReady, memWrEn, skipNext, carryFlag, zeroFlag, signedOverflowFlag;
	logic halfCarryFlag, signCompareFlag, chainedNullFlag;
	logic [7:0] memWrData, memData, workingReg, st, fl;
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	assign fl = {2'h0, carryFlag, zeroFlag, halfCarryFlag, signedOverflowFlag,
		signCompareFlag, chainedNullFlag};

	rssd_datapath i_rssd_datapath (
		.sys_clk, .rst_b, .opValid, .opCode, .memData, .immData, .bitSel, .opReady,
		.memWrEn, .memWrData, .skipNext, .workingReg, .carryFlag, .zeroFlag,
		.signedOverflowFlag, .halfCarryFlag, .signCompareFlag, .chainedNullFlag
	);
	rssd_mem_model i_rssd_mem_model (
		.sys_clk, .rst_b, .ld, .ldVal, .memWrEn, .memWrData, .memData
	);

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 1000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Pulse byte es is {ready, skip, write} in the cycle after the take.
	task automatic ex(input rssd_op_t o, input logic [7:0] m, input logic [7:0] ew,
		input logic [7:0] em, input logic [7:0] es, input logic [7:0] ef);
		@(posedge sys_clk) #1 ld = 1'b1;
		ldVal = m;
		@(posedge sys_clk) #1 ld = 1'b0;
		opCode = o;
		opValid = 1'b1;
		@(posedge sys_clk) #1 opValid = 1'b0;
		st = {5'h00, opReady, skipNext, memWrEn};
		@(posedge sys_clk) #1 chk("memory", memData, em);
		chk("wreg", workingReg, ew);
		chk("pulses", st, es);
		chk("flags", fl, ef);
	endtask : ex

	task automatic t_rotate();
		ex(OP_ROTL_THRU_CARRY_TO_WREG,8'h81,8'h02,8'h81,8'h04,8'h20);
		ex(OP_ROTR_THRU_CARRY_TO_WREG,8'h02,8'h81,8'h02,8'h04,8'h00);
		ex(OP_ROTATE_RIGHT_INPLACE,8'h01,8'h81,8'h80,8'h05,8'h00);
		ex(OP_ROTR_THRU_CARRY_INPLACE,8'h01,8'h81,8'h00,8'h05,8'h20);
	endtask : t_rotate

	task automatic t_subtract();
		ex(OP_ROTATE_RIGHT_TO_WREG,8'h0a,8'h05,8'h0a,8'h04,8'h20);
		ex(OP_MINUS_PLAIN,8'h03,8'h02,8'h03,8'h04,8'h28);
		ex(OP_MINUS_PLAIN_TO_MEM,8'h05,8'h02,8'hfd,8'h05,8'h02);
		immData = 8'h01;
		ex(OP_MINUS_WITH_BORROW_IMM,8'h00,8'h00,8'h00,8'h04,8'h38);
		immData = 8'h00;
		ex(OP_MINUS_PLAIN_IMM,8'h00,8'h00,8'h00,8'h04,8'h39);
		ex(OP_MINUS_WITH_BORROW,8'h00,8'h00,8'h00,8'h04,8'h39);
		ex(OP_MINUS_WITH_BORROW,8'h01,8'hff,8'h01,8'h04,8'h02);
		ex(OP_ROTATE_RIGHT_TO_WREG,8'h01,8'h80,8'h01,8'h04,8'h02);
		ex(OP_MINUS_WITH_BORROW_TO_MEM,8'h00,8'h80,8'h7f,8'h05,8'h26);
	endtask : t_subtract

	task automatic t_skip();
		ex(OP_DECREMENT_SKIP_NULL,8'h01,8'h80,8'h00,8'h03,8'h26);
		ex(OP_DECREMENT_SKIP_NULL,8'h00,8'h80,8'hff,8'h01,8'h26);
		ex(OP_INCREMENT_SKIP_NULL,8'hff,8'h80,8'h00,8'h03,8'h26);
		ex(OP_DECREMENT_SKIP_NULL_WREG,8'h05,8'h04,8'h05,8'h00,8'h26);
		ex(OP_INCREMENT_SKIP_NULL_WREG,8'hff,8'h00,8'hff,8'h02,8'h26);
		bitSel = 3'h3;
		ex(OP_SKIP_BIT_NONNULL,8'h08,8'h00,8'h08,8'h02,8'h26);
		bitSel = 3'h2;
		ex(OP_SKIP_BIT_NONNULL,8'h08,8'h00,8'h08,8'h00,8'h26);
		ex(OP_SKIP_IF_NONNULL,8'h40,8'h00,8'h40,8'h03,8'h26);
		ex(OP_SKIP_IF_NONNULL,8'h00,8'h00,8'h00,8'h01,8'h26);
	endtask : t_skip

	task automatic t_misc();
		ex(OP_SET_BYTE,8'h12,8'h00,8'hff,8'h05,8'h26);
		for (int i = 0; i < 8; i++) begin
			bitSel = 3'(i);
			ex(OP_SET_BIT,8'h5a,8'h00,8'h5a|(8'h01<<i),8'h05,8'h26);
		end
		ex(OP_NIBBLE_EXCHANGE_INPLACE,8'h3c,8'h00,8'hc3,8'h05,8'h26);
		ex(OP_NIBBLE_EXCHANGE_TO_WREG,8'ha5,8'h5a,8'ha5,8'h04,8'h26);
	endtask : t_misc

	initial begin
		repeat (20) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		t_rotate();
		t_subtract();
		t_skip();
		t_misc();
		finish_test();
	end
endmodule : tb_rssd_datapath

`default_nettype wire
